/* setpoint_command_bank.v */
`timescale 1ns/1ns
`include "setpoint_bank_regs.vh"

// Behaviour
// [R1] user trim offset added to command value
// [R2] factory calibration offset added to command value
// [R3] trim/cal writes refused in identification-code format
// [R4] trim and calibration reset to zero
// [R5] setpoints are two bytes, current format
// [R6] upper clamp limits every commanded voltage
// [R7] over-clamp request commands the clamp value
// [R8] clamp violation sets three status bits, alerts
// [R9] clamp violation is warning, never fault
// [R10] margin setpoints used when margin selected
// [R11] voltage changes slew at programmed rate
// [R12] no slew limit on turn on/off
// [R13] all-ones rate means fastest change
// [R14] output lowered by current times droop
// [R15] droop uses own measured current only
// [R16] both scale factors reset to one
// [R17] rate, droop, scales, limits are two-byte literals
// [R18] coefficients read via write-then-read process call
// [R19] coefficient bytes are unsigned integers
// [R20] constant-power mode at power limit
// [R21] duty cycle never exceeds duty limit
// [R22] operation mode selects margin high/low
// [R23] target is command+trim+cal, then clamped
module setpoint_command_bank (
   input wire clock,
   input wire resetn,
   input wire cmd_valid,
   input wire [1:0] cmd_kind,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   output reg rsp_valid,
   output reg rsp_ack,
   output reg [15:0] rsp_rdata,
   output reg [7:0] rsp_exponent,
   input wire [15:0] output_voltage_command,
   input wire output_voltage_format_selector,
   input wire unit_on,
   input wire [1:0] margin_select,
   input wire [15:0] measured_current,
   input wire [15:0] measured_power,
   input wire [15:0] duty_demand,
   input wire status_clear,
   output reg [15:0] vout_setpoint,
   output reg clamp_active,
   output reg status_other,
   output reg status_word_vout,
   output reg status_clamp_warn,
   output reg host_alert,
   output reg fault_event,
   output reg constant_power_mode,
   output reg [15:0] duty_limited,
   output reg [15:0] loop_scale,
   output reg [15:0] monitor_scale
);

   parameter [7:0] COEF_SLOPE = 8'h01;
   parameter [7:0] COEF_OFFSET = 8'h00;
   parameter [7:0] COEF_EXPONENT = 8'h00;

   // ------------------------------------------------------------
   // decoding shared by read, write and reset paths
   // ------------------------------------------------------------
   function [3:0] code_index;
      input [7:0] code;
      begin
         case (code)
            `CODE_TRIM: code_index = `IDX_TRIM;
            `CODE_CAL: code_index = `IDX_CAL;
            `CODE_CLAMP: code_index = `IDX_CLAMP;
            `CODE_MARGIN_HIGH: code_index = `IDX_MARGIN_HIGH;
            `CODE_MARGIN_LOW: code_index = `IDX_MARGIN_LOW;
            `CODE_SLEW: code_index = `IDX_SLEW;
            `CODE_DROOP: code_index = `IDX_DROOP;
            `CODE_LOOP_SCALE: code_index = `IDX_LOOP_SCALE;
            `CODE_MON_SCALE: code_index = `IDX_MON_SCALE;
            `CODE_COEFFS: code_index = `IDX_COEFFS;
            `CODE_POWER_LIMIT: code_index = `IDX_POWER_LIMIT;
            `CODE_DUTY_LIMIT: code_index = `IDX_DUTY_LIMIT;
            default: code_index = `IDX_NONE;
         endcase
      end
   endfunction

   function [15:0] reset_value;
      input [31:0] idx;
      begin
         case (idx)
            `IDX_TRIM: reset_value = `RST_TRIM; // [R4]
            `IDX_CAL: reset_value = `RST_CAL; // [R4]
            `IDX_CLAMP: reset_value = `RST_CLAMP;
            `IDX_MARGIN_HIGH: reset_value = `RST_MARGIN_HIGH;
            `IDX_MARGIN_LOW: reset_value = `RST_MARGIN_LOW;
            `IDX_SLEW: reset_value = `RST_SLEW;
            `IDX_DROOP: reset_value = `RST_DROOP;
            `IDX_LOOP_SCALE: reset_value = `RST_LOOP_SCALE; // [R16]
            `IDX_MON_SCALE: reset_value = `RST_MON_SCALE; // [R16]
            `IDX_POWER_LIMIT: reset_value = `RST_POWER_LIMIT;
            `IDX_DUTY_LIMIT: reset_value = `RST_DUTY_LIMIT;
            default: reset_value = 16'h0000;
         endcase
      end
   endfunction

   function is_offset;
      input [3:0] idx;
      begin
         is_offset = (idx == `IDX_TRIM) || (idx == `IDX_CAL);
      end
   endfunction

   // ------------------------------------------------------------
   // command acceptance
   // ------------------------------------------------------------
   wire [3:0] cmd_idx = code_index(cmd_code);
   wire cmd_known = (cmd_idx != `IDX_NONE);
   wire [3:0] query_idx = code_index(cmd_wdata[7:0]);
   wire offset_locked = output_voltage_format_selector && is_offset(cmd_idx); // [R3]
   wire write_ok = cmd_valid && cmd_kind == `KIND_WRITE && cmd_known &&
                   cmd_idx != `IDX_COEFFS && !offset_locked;
   wire process_ok = cmd_valid && cmd_kind == `KIND_PROCESS && cmd_idx == `IDX_COEFFS &&
                     query_idx != `IDX_NONE && query_idx != `IDX_COEFFS; // [R18]
   wire read_ok = cmd_valid && cmd_kind == `KIND_READ && cmd_known && cmd_idx != `IDX_COEFFS;

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   reg [15:0] bank [0:`REG_COUNT-1];

   // each word holds raw bytes; format is interpreted downstream, not here
   genvar gi;
   generate
      for (gi = 0; gi < `REG_COUNT; gi = gi + 1) begin : store
         if (gi != `IDX_COEFFS) begin : rw
            always @(posedge clock or negedge resetn) begin
               if (!resetn) begin
                  bank[gi] <= reset_value(gi); // [R4] [R16]
               end else if (write_ok && cmd_idx == gi) begin // [R5] [R17]
                  bank[gi] <= cmd_wdata;
               end
            end
         end else begin : ro
            always @(posedge clock or negedge resetn) begin
               if (!resetn) begin
                  bank[gi] <= 16'h0000;
               end else begin
                  bank[gi] <= {COEF_OFFSET, COEF_SLOPE};
               end
            end
         end
      end
   endgenerate

   wire [15:0] trim = bank[`IDX_TRIM];
   wire [15:0] cal = bank[`IDX_CAL];
   wire [15:0] upper_clamp = bank[`IDX_CLAMP];
   wire [15:0] slew_rate = bank[`IDX_SLEW];
   wire [15:0] droop = bank[`IDX_DROOP];

   // ------------------------------------------------------------
   // response: one cycle after the request
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_ack <= 1'b0;
         rsp_rdata <= 16'h0000;
         rsp_exponent <= 8'h00;
      end else begin
         rsp_valid <= cmd_valid;
         rsp_ack <= write_ok || read_ok || process_ok; // [R3]
         if (read_ok) begin
            rsp_rdata <= bank[cmd_idx];
            rsp_exponent <= 8'h00;
         end else if (process_ok) begin
            // one coefficient set for all formatted commands
            rsp_rdata <= bank[`IDX_COEFFS]; // [R18] [R19]
            rsp_exponent <= COEF_EXPONENT; // [R18]
         end else begin
            rsp_rdata <= 16'h0000;
            rsp_exponent <= 8'h00;
         end
      end
   end

   // ------------------------------------------------------------
   // target voltage: base, offsets, clamp
   // ------------------------------------------------------------
   reg [15:0] base;

   always @* begin
      case (margin_select) // [R10] [R22]
         `MARGIN_LOW: base = bank[`IDX_MARGIN_LOW];
         `MARGIN_HIGH: base = bank[`IDX_MARGIN_HIGH];
         default: base = output_voltage_command;
      endcase
   end

   // two guard bits so a large positive sum or a negative one is not wrapped
   wire [17:0] offset_sum = {2'b00, base} + {{2{trim[15]}}, trim} + // [R1] [R23]
                            {{2{cal[15]}}, cal}; // [R2] [R23]
   wire sum_negative = offset_sum[17];
   wire over_clamp = !sum_negative && (offset_sum[16:0] > {1'b0, upper_clamp}); // [R6] [R23]
   reg [15:0] commanded;

   always @* begin
      if (sum_negative) begin
         commanded = 16'h0000;
      end else if (over_clamp) begin
         commanded = upper_clamp; // [R7]
      end else begin
         commanded = offset_sum[15:0];
      end
   end

   // ------------------------------------------------------------
   // clamp warning status
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         clamp_active <= 1'b0;
         status_other <= 1'b0;
         status_word_vout <= 1'b0;
         status_clamp_warn <= 1'b0;
         host_alert <= 1'b0;
         fault_event <= 1'b0;
      end else begin
         clamp_active <= over_clamp;
         // a set in the clear cycle wins, so no violation is lost
         status_other <= over_clamp || (status_other && !status_clear); // [R8]
         status_word_vout <= over_clamp || (status_word_vout && !status_clear); // [R8]
         status_clamp_warn <= over_clamp || (status_clamp_warn && !status_clear); // [R8]
         host_alert <= over_clamp || (host_alert && !status_clear); // [R8]
         // only a warning: the fault path never sees the clamp
         fault_event <= 1'b0; // [R9]
      end
   end

   // ------------------------------------------------------------
   // slew and on/off handling
   // ------------------------------------------------------------
   reg unit_on_seen;
   wire on_off_edge = (unit_on != unit_on_seen);
   wire [15:0] ramp_target = unit_on ? commanded : 16'h0000;
   wire [15:0] ramp_level;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         unit_on_seen <= 1'b0;
      end else begin
         unit_on_seen <= unit_on;
      end
   end

   slew_ramp ramp (
      .clock(clock),
      .resetn(resetn),
      .target(ramp_target),
      .rate(slew_rate),
      .bypass(on_off_edge || !unit_on), // [R12]
      .level(ramp_level)
   );

   // ------------------------------------------------------------
   // droop from this unit's own current
   // ------------------------------------------------------------
   // no sharing input exists, so paralleled units cannot skew the drop
   wire [31:0] droop_product = measured_current * droop; // [R14] [R15]
   wire [31:0] droop_scaled = droop_product >> `DROOP_SHIFT;
   wire droop_big = (droop_scaled[31:16] != 16'h0000);
   wire [15:0] droop_drop = droop_big ? 16'hFFFF : droop_scaled[15:0];

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         vout_setpoint <= 16'h0000;
      end else if (ramp_level > droop_drop) begin
         vout_setpoint <= ramp_level - droop_drop; // [R14]
      end else begin
         vout_setpoint <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // power and duty limits, scale outputs
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         constant_power_mode <= 1'b0;
         duty_limited <= 16'h0000;
         loop_scale <= `RST_LOOP_SCALE; // [R16]
         monitor_scale <= `RST_MON_SCALE; // [R16]
      end else begin
         constant_power_mode <= (measured_power >= bank[`IDX_POWER_LIMIT]); // [R20]
         if (duty_demand > bank[`IDX_DUTY_LIMIT]) begin
            duty_limited <= bank[`IDX_DUTY_LIMIT]; // [R21]
         end else begin
            duty_limited <= duty_demand;
         end
         loop_scale <= bank[`IDX_LOOP_SCALE];
         monitor_scale <= bank[`IDX_MON_SCALE];
      end
   end

endmodule

/* setpoint_bank_regs.vh */
`ifndef SETPOINT_BANK_REGS_VH
`define SETPOINT_BANK_REGS_VH

// ------------------------------------------------------------
// command codes seen on the command port
// ------------------------------------------------------------
`define CODE_TRIM          8'h22
`define CODE_CAL           8'h23
`define CODE_CLAMP         8'h24
`define CODE_MARGIN_HIGH   8'h25
`define CODE_MARGIN_LOW    8'h26
`define CODE_SLEW          8'h27
`define CODE_DROOP         8'h28
`define CODE_LOOP_SCALE    8'h29
`define CODE_MON_SCALE     8'h2A
`define CODE_COEFFS        8'h30
`define CODE_POWER_LIMIT   8'h31
`define CODE_DUTY_LIMIT    8'h32

// ------------------------------------------------------------
// storage index of each register
// ------------------------------------------------------------
`define IDX_TRIM           4'h0
`define IDX_CAL            4'h1
`define IDX_CLAMP          4'h2
`define IDX_MARGIN_HIGH    4'h3
`define IDX_MARGIN_LOW     4'h4
`define IDX_SLEW           4'h5
`define IDX_DROOP          4'h6
`define IDX_LOOP_SCALE     4'h7
`define IDX_MON_SCALE      4'h8
`define IDX_COEFFS         4'h9
`define IDX_POWER_LIMIT    4'hA
`define IDX_DUTY_LIMIT     4'hB
`define IDX_NONE           4'hF
`define REG_COUNT          12

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_TRIM           16'h0000
`define RST_CAL            16'h0000
`define RST_CLAMP          16'hFFFF
`define RST_MARGIN_HIGH    16'h0000
`define RST_MARGIN_LOW     16'h0000
`define RST_SLEW           16'hFFFF
`define RST_DROOP          16'h0000
`define RST_LOOP_SCALE     16'h0001
`define RST_MON_SCALE      16'h0001
`define RST_POWER_LIMIT    16'hFFFF
`define RST_DUTY_LIMIT     16'hFFFF

// ------------------------------------------------------------
// command kinds, margin states, fields
// ------------------------------------------------------------
`define KIND_READ          2'h0
`define KIND_WRITE         2'h1
`define KIND_PROCESS       2'h2
`define MARGIN_NONE        2'h0
`define MARGIN_LOW         2'h1
`define MARGIN_HIGH        2'h2
`define SLEW_FASTEST       16'hFFFF
`define DROOP_SHIFT        10

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLOCK_PERIOD_NS    40
`define SLEW_TICK_NS       1000
`define SLEW_TICK_CYCLES   ((`SLEW_TICK_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

/* slew_ramp.v */
`timescale 1ns/1ns
`include "setpoint_bank_regs.vh"

module slew_ramp (
   input wire clock,
   input wire resetn,
   input wire [15:0] target,
   input wire [15:0] rate,
   input wire bypass,
   output reg [15:0] level
);

   localparam [31:0] tick_last_full = `SLEW_TICK_CYCLES - 1;
   localparam [7:0] tick_last = tick_last_full[7:0];

   reg [7:0] tick_count;
   wire tick = (tick_count == tick_last);
   wire [15:0] up_gap = target - level;
   wire [15:0] down_gap = level - target;

   // ------------------------------------------------------------
   // one microsecond step timer
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tick_count <= 8'h00;
      end else if (tick) begin
         tick_count <= 8'h00;
      end else begin
         tick_count <= tick_count + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // ramp: rate is steps per microsecond, never overshoots
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         level <= 16'h0000;
      end else if (bypass || rate == `SLEW_FASTEST) begin // [R12] [R13]
         level <= target;
      end else if (tick && level < target) begin // [R11]
         level <= (up_gap > rate) ? level + rate : target;
      end else if (tick && level > target) begin // [R11]
         level <= (down_gap > rate) ? level - rate : target;
      end
   end

endmodule

/* setpoint_command_bank_asserts.sv */
`timescale 1ns/1ns
`include "setpoint_bank_regs.vh"
// ------------------------------------------------------------
// port checker for the setpoint command bank
// ------------------------------------------------------------
module setpoint_command_bank_asserts #(
   parameter [7:0] COEF_SLOPE = 8'h01,
   parameter [7:0] COEF_OFFSET = 8'h00,
   parameter [7:0] COEF_EXPONENT = 8'h00
) (
   input logic clock,
   input logic resetn,
   input logic cmd_valid,
   input logic [1:0] cmd_kind,
   input logic [7:0] cmd_code,
   input logic [15:0] cmd_wdata,
   input logic rsp_valid,
   input logic rsp_ack,
   input logic [15:0] rsp_rdata,
   input logic [7:0] rsp_exponent,
   input logic output_voltage_format_selector,
   input logic status_clear,
   input logic clamp_active,
   input logic status_other,
   input logic status_word_vout,
   input logic status_clamp_warn,
   input logic host_alert,
   input logic fault_event,
   input logic constant_power_mode,
   input logic [15:0] measured_power,
   input logic [15:0] duty_demand,
   input logic [15:0] duty_limited
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_offset_lock: assert property (
      cmd_valid && cmd_kind == `KIND_WRITE && (cmd_code == `CODE_TRIM || cmd_code == `CODE_CAL)
      && output_voltage_format_selector |=> rsp_valid && !rsp_ack)
      else $error("offset write accepted in id-code format");
   a_coef_answer: assert property (
      cmd_valid && cmd_kind == `KIND_PROCESS && cmd_code == `CODE_COEFFS && cmd_wdata[7:0] == `CODE_SLEW
      |=> rsp_valid && rsp_ack && rsp_rdata == {COEF_OFFSET, COEF_SLOPE} && rsp_exponent == COEF_EXPONENT)
      else $error("coefficient answer wrong");
   a_coef_readonly: assert property (
      cmd_valid && cmd_kind == `KIND_WRITE && cmd_code == `CODE_COEFFS |=> rsp_valid && !rsp_ack)
      else $error("coefficient write accepted");
   a_never_fault: assert property (!fault_event)
      else $error("fault raised");
   a_clamp_flags: assert property (
      clamp_active |-> status_other && status_word_vout && status_clamp_warn && host_alert)
      else $error("clamp flags missing");
   a_warn_sticky: assert property (
      status_clamp_warn && !status_clear |=> status_clamp_warn)
      else $error("warning dropped without clear");
   a_duty_cap: assert property (duty_limited <= $past(duty_demand))
      else $error("duty above demand");
   a_power_mode: assert property (measured_power == 16'hFFFF |=> constant_power_mode)
      else $error("full power without constant-power mode");
endmodule

bind setpoint_command_bank setpoint_command_bank_asserts #(
   .COEF_SLOPE(COEF_SLOPE), .COEF_OFFSET(COEF_OFFSET), .COEF_EXPONENT(COEF_EXPONENT)
) u_asserts (.clock, .resetn, .cmd_valid, .cmd_kind, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_ack,
   .rsp_rdata, .rsp_exponent, .output_voltage_format_selector, .status_clear, .clamp_active,
   .status_other, .status_word_vout, .status_clamp_warn, .host_alert, .fault_event,
   .constant_power_mode, .measured_power, .duty_demand, .duty_limited);

/* bus_host.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// management bus host: one request, then wait for its answer
// ------------------------------------------------------------
module bus_host (
   input logic clock,
   output logic cmd_valid,
   output logic [1:0] cmd_kind,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   input logic rsp_valid,
   input logic rsp_ack,
   input logic [15:0] rsp_rdata,
   input logic [7:0] rsp_exponent
);
   initial begin
      cmd_valid = 1'b0;
      cmd_kind = 2'h0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // process call carries the queried code in the low data byte
   task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d,
         output logic a, output logic [15:0] r, output logic [7:0] e, output logic ok);
      int n;
      ok = 1'b0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      // idle data flips so nothing can lean on a stale word
      cmd_wdata <= ~d;
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge clock);
         if (rsp_valid === 1'b1) begin
            ok = 1'b1;
            a = rsp_ack;
            r = rsp_rdata;
            e = rsp_exponent;
         end
      end
   endtask
endmodule

/* tb_setpoint_command_bank.sv */
`timescale 1ns/1ns
`include "setpoint_bank_regs.vh"
module tb_setpoint_command_bank;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid, rsp_valid, rsp_ack, clamp_active, status_other, status_word_vout;
   logic status_clamp_warn, host_alert, fault_event, constant_power_mode;
   logic [1:0] cmd_kind;
   logic [7:0] cmd_code, rsp_exponent;
   logic [15:0] cmd_wdata, rsp_rdata, vout_setpoint, duty_limited, loop_scale, monitor_scale;
   logic [15:0] output_voltage_command = 16'h0100;
   logic output_voltage_format_selector = 1'b0;
   logic unit_on = 1'b0;
   logic status_clear = 1'b0;
   logic [1:0] margin_select = `MARGIN_NONE;
   logic [15:0] measured_current = 16'h0000;
   logic [15:0] measured_power = 16'h0000;
   logic [15:0] duty_demand = 16'h0000;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   int i;
   logic ack, ok;
   logic [15:0] rd;
   logic [7:0] ex;
   typedef struct {logic [7:0] code; logic [15:0] rst; logic [15:0] wr;} row_t;
   row_t rows [11];
   logic [15:0] pw [3] = '{16'hFFFF, 16'h0100, 16'h00FF};
   logic pm [3] = '{1'b1, 1'b1, 1'b0};

   always #20 clock = ~clock;

   setpoint_command_bank u_dut (.clock, .resetn, .cmd_valid, .cmd_kind, .cmd_code, .cmd_wdata,
      .rsp_valid, .rsp_ack, .rsp_rdata, .rsp_exponent, .output_voltage_command,
      .output_voltage_format_selector, .unit_on, .margin_select, .measured_current, .measured_power,
      .duty_demand, .status_clear, .vout_setpoint, .clamp_active, .status_other, .status_word_vout,
      .status_clamp_warn, .host_alert, .fault_event, .constant_power_mode, .duty_limited,
      .loop_scale, .monitor_scale);
   bus_host u_host (.clock, .cmd_valid, .cmd_kind, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_ack,
      .rsp_rdata, .rsp_exponent);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task cmd(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d, input logic ea,
         input logic [15:0] er);
      u_host.xfer(k, c, d, ack, rd, ex, ok);
      check({15'h0000, ok}, 16'h0001);
      check({15'h0000, ack}, {15'h0000, ea});
      check(rd, er);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task report_and_stop;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // a hang costs at most this many cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop;
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rows[0] = '{`CODE_TRIM, `RST_TRIM, 16'h0010};
      rows[1] = '{`CODE_CAL, `RST_CAL, 16'h0004};
      rows[2] = '{`CODE_CLAMP, `RST_CLAMP, 16'h0200};
      rows[3] = '{`CODE_MARGIN_HIGH, `RST_MARGIN_HIGH, 16'h0180};
      rows[4] = '{`CODE_MARGIN_LOW, `RST_MARGIN_LOW, 16'h0080};
      rows[5] = '{`CODE_SLEW, `RST_SLEW, 16'h0001};
      rows[6] = '{`CODE_DROOP, `RST_DROOP, 16'h0400};
      rows[7] = '{`CODE_LOOP_SCALE, `RST_LOOP_SCALE, 16'h1234};
      rows[8] = '{`CODE_MON_SCALE, `RST_MON_SCALE, 16'h5678};
      rows[9] = '{`CODE_POWER_LIMIT, `RST_POWER_LIMIT, 16'h0100};
      rows[10] = '{`CODE_DUTY_LIMIT, `RST_DUTY_LIMIT, 16'h0300};
      cyc(4);
      resetn <= 1'b1;
      cyc(1);
      check(loop_scale, 16'h0001);
      check(monitor_scale, 16'h0001);
      for (i = 0; i < 11; i++) begin
         cmd(`KIND_READ, rows[i].code, 16'h0000, 1'b1, rows[i].rst);
         cmd(`KIND_WRITE, rows[i].code, rows[i].wr, 1'b1, 16'h0000);
         cmd(`KIND_READ, rows[i].code, 16'h0000, 1'b1, rows[i].wr);
      end
      check(loop_scale, 16'h1234);
      check(monitor_scale, 16'h5678);
      $display("test registers done");
      output_voltage_format_selector <= 1'b1;
      cmd(`KIND_WRITE, `CODE_TRIM, 16'h0077, 1'b0, 16'h0000);
      cmd(`KIND_WRITE, `CODE_CAL, 16'h0077, 1'b0, 16'h0000);
      // the lock is only for the two offsets
      cmd(`KIND_WRITE, `CODE_MARGIN_HIGH, 16'h0180, 1'b1, 16'h0000);
      output_voltage_format_selector <= 1'b0;
      cmd(`KIND_READ, `CODE_TRIM, 16'h0000, 1'b1, 16'h0010);
      cmd(`KIND_READ, `CODE_CAL, 16'h0000, 1'b1, 16'h0004);
      cmd(`KIND_PROCESS, `CODE_COEFFS, 16'h0027, 1'b1, 16'h0001);
      check({8'h00, ex}, 16'h0000);
      cmd(`KIND_WRITE, `CODE_COEFFS, 16'h1111, 1'b0, 16'h0000);
      cmd(`KIND_READ, `CODE_COEFFS, 16'h0000, 1'b0, 16'h0000);
      cmd(2'h3, `CODE_TRIM, 16'h0000, 1'b0, 16'h0000);
      cmd(`KIND_PROCESS, `CODE_TRIM, 16'h0027, 1'b0, 16'h0000);
      cmd(`KIND_PROCESS, `CODE_COEFFS, 16'h0030, 1'b0, 16'h0000);
      cmd(`KIND_READ, 8'h00, 16'h0000, 1'b0, 16'h0000);
      $display("test refusals done");
      cmd(`KIND_WRITE, `CODE_SLEW, `SLEW_FASTEST, 1'b1, 16'h0000);
      unit_on <= 1'b1;
      cyc(4);
      check(vout_setpoint, 16'h0114);
      margin_select <= `MARGIN_HIGH;
      cyc(4);
      check(vout_setpoint, 16'h0194);
      margin_select <= `MARGIN_LOW;
      cyc(4);
      check(vout_setpoint, 16'h0094);
      margin_select <= `MARGIN_NONE;
      output_voltage_command <= 16'h01F0;
      cyc(4);
      check(vout_setpoint, 16'h0200);
      check({10'h000, clamp_active, status_other, status_word_vout, status_clamp_warn, host_alert,
         fault_event}, 16'h003E);
      output_voltage_command <= 16'h0100;
      cyc(4);
      check({15'h0000, status_clamp_warn}, 16'h0001);
      status_clear <= 1'b1;
      cyc(1);
      status_clear <= 1'b0;
      cyc(2);
      check({12'h000, status_other, status_word_vout, status_clamp_warn, host_alert}, 16'h0000);
      measured_current <= 16'h0010;
      cyc(4);
      check(vout_setpoint, 16'h0104);
      measured_current <= 16'h0000;
      $display("test setpoint done");
      // a one-LSB rate must not jump; only the slow tick may move it
      cmd(`KIND_WRITE, `CODE_SLEW, 16'h0001, 1'b1, 16'h0000);
      output_voltage_command <= 16'h0102;
      cyc(3);
      check({15'h0000, vout_setpoint < 16'h0116}, 16'h0001);
      cyc(80);
      check(vout_setpoint, 16'h0116);
      unit_on <= 1'b0;
      cyc(4);
      check(vout_setpoint, 16'h0000);
      unit_on <= 1'b1;
      cyc(4);
      check(vout_setpoint, 16'h0116);
      $display("test slew done");
      for (i = 0; i < 3; i++) begin
         measured_power <= pw[i];
         cyc(3);
         check({15'h0000, constant_power_mode}, {15'h0000, pm[i]});
      end
      duty_demand <= 16'h0400;
      cyc(3);
      check(duty_limited, 16'h0300);
      duty_demand <= 16'h0200;
      cyc(3);
      check(duty_limited, 16'h0200);
      $display("test limits done");
      // second reset in mid-run: written values must not survive it
      resetn <= 1'b0;
      cyc(2);
      resetn <= 1'b1;
      cyc(1);
      check(loop_scale, 16'h0001);
      cmd(`KIND_READ, `CODE_TRIM, 16'h0000, 1'b1, `RST_TRIM);
      cmd(`KIND_READ, `CODE_CAL, 16'h0000, 1'b1, `RST_CAL);
      cmd(`KIND_READ, `CODE_MON_SCALE, 16'h0000, 1'b1, 16'h0001);
      $display("test second reset done");
      report_and_stop;
   end
endmodule
